// ---- pwmcs_pkg.sv ----
// constants for the pulse width control and clock select block
package pwmcs_pkg;

   // ==================================================================
   // register map: printed offsets are indexes, byte address = index * 4
   localparam logic [11:0] BLOCKING_BASE     = 12'h200;
   localparam logic [11:0] NONBLOCKING_BASE  = 12'h300;
   localparam logic [11:0] IDX_CHAN_CTRL     = 12'h060;
   localparam logic [11:0] IDX_PRESCALE_SEL  = 12'h061;
   localparam logic [11:0] IDX_SCALE_A       = 12'h062;
   localparam int          ADDR_W            = 14;

   // ==================================================================
   // reset values
   localparam logic [7:0] CHAN_CTRL_RST     = 8'h00;
   localparam logic [7:0] PRESCALE_SEL_RST  = 8'h00;
   localparam logic [7:0] SCALE_A_RST       = 8'h00;

   // ==================================================================
   // field positions in channel_control
   localparam int CTRL_ALIGN_LSB  = 6;
   localparam int CTRL_CLK1_POS   = 5;
   localparam int CTRL_CLK0_POS   = 4;
   localparam int CTRL_LEVEL_LSB  = 2;
   localparam int CTRL_ON_LSB     = 0;

   // field positions in prescale_select
   localparam int PRE_B_LSB  = 4;
   localparam int PRE_A_LSB  = 0;
   localparam logic [7:0] PRE_WRITE_MASK = 8'h77;

   // ==================================================================
   // prescaler counter width, enough for divide by 128
   localparam int PRE_CNT_W = 7;

   // ==================================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pwmcs_pkg

// ---- pwmcs_scaler.sv ----
// scale divider: one output pulse per 2*scale input pulses
`timescale 1ns/1ps
module pwmcs_scaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       load,
   input  wire logic [7:0] scale,
   input  wire logic       tick_in,
   output logic            tick_out
);
   import pwmcs_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       phase;
   } pwmcs_scl_t;

   pwmcs_scl_t st_r;
   pwmcs_scl_t st_nxt;

   // ==================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      // (RL16) a write to the scale register reloads
      if (load) begin
         st_nxt.cnt   = scale;
         st_nxt.phase = 1'b0;
      end else if (tick_in) begin
         // (RL15) zero counts as 256: 0 wraps through 255 down to 1
         if (st_r.cnt == 8'h01) begin
            st_nxt.cnt   = scale;
            st_nxt.phase = ~st_r.phase;
         end else begin
            st_nxt.cnt = st_r.cnt - 8'h01;
         end
      end
   end

   // (RL14) one pulse per two half periods of scale ticks
   // (RL23) scaled clock is an enable pulse, not a clock net
   assign tick_out = tick_in && !load && (st_r.cnt == 8'h01) && st_r.phase;

   // ==================================================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.cnt   <= SCALE_A_RST;
         st_r.phase <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : pwmcs_scaler

// ---- pwmcs_top.sv ----
// two-channel pulse width control, prescaler and clock select front end
//
// Overview of operation
// (RL1) alignment bit one means center aligned
// (RL2) channel 1 uses clock B or scaled B
// (RL3) channel 0 uses clock A or scaled A
// (RL4) level one: start high, low at match
// (RL5) level zero: start low, high at match
// (RL6) output starts on next selected clock tick
// (RL7) prescaler stops when both channels off
// (RL8) level bits writable anytime, applied at once
// (RL9) clock selects writable anytime, no deferral
// (RL10) prescale selects writable anytime, applied at once
// (RL11) software changes alignment only while disabled
// (RL12) clock B is interface clock over 2^sel
// (RL13) clock A is interface clock over 2^sel
// (RL14) scaled A is clock A over 2*scale
// (RL15) scale zero counts as 256
// (RL16) scale write reloads scale counter
// (RL17) registers at both blocking and nonblocking bases
// (RL18) control register resets to zero
// (RL19) reserved bits read zero, ignore writes
// (RL20) interface clock is the base clock
// (RL21) one waveform output per channel
// (RL22) prescale and scale registers reset zero
// (RL23) scaled clock A is enable pulse
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module pwmcs_top (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // AXI4-Lite slave
   input  wire logic [pwmcs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [pwmcs_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // counter side of each channel
   input  wire logic [1:0]                  period_start,
   input  wire logic [1:0]                  duty_match,
   input  wire logic                        scaled_clock_b,
   output logic                             clock_b_tick,
   output logic [1:0]                       chan_tick,
   output logic [1:0]                       chan_run,
   output logic [1:0]                       center_align_sel,
   output logic                             wave_out_0,
   output logic                             wave_out_1
);
   import pwmcs_pkg::*;

   // ==================================================================
   // state
   typedef struct packed {
      logic [7:0]           ctrl;
      logic [7:0]           pre;
      logic [7:0]           scl_a;
      logic [PRE_CNT_W-1:0] pre_cnt;
      logic [1:0]           run;
      logic [1:0]           past_match;
      logic [1:0]           wave;
      logic                 aw_got;
      logic [ADDR_W-1:0]    aw_addr;
      logic                 w_got;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } pwmcs_state_t;

   pwmcs_state_t st_r;
   pwmcs_state_t st_nxt;

   logic       clock_a_tick;
   logic       scaled_a_tick;
   logic       scale_load;
   logic [7:0] scale_val;
   logic [1:0] sel_tick;
   logic [1:0] start_level;
   logic [1:0] chan_on;

   // ==================================================================
   // helpers
   // one pulse every 2^sel cycles of the free prescaler count
   function automatic logic pre_tick(input logic [PRE_CNT_W-1:0] cnt,
                                     input logic [2:0] sel);
      logic [PRE_CNT_W-1:0] mask;
      mask = PRE_CNT_W'((8'h01 << sel) - 8'h01);
      return (cnt & mask) == mask;
   endfunction : pre_tick

   // (RL17) register index for either window; 3 = unmapped
   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
      logic [11:0] idx;
      idx = addr[ADDR_W-1:2];
      if (idx == BLOCKING_BASE + IDX_CHAN_CTRL
          || idx == NONBLOCKING_BASE + IDX_CHAN_CTRL)
         return 2'd0;
      else if (idx == BLOCKING_BASE + IDX_PRESCALE_SEL
               || idx == NONBLOCKING_BASE + IDX_PRESCALE_SEL)
         return 2'd1;
      else if (idx == BLOCKING_BASE + IDX_SCALE_A
               || idx == NONBLOCKING_BASE + IDX_SCALE_A)
         return 2'd2;
      else
         return 2'd3;
   endfunction : reg_sel

   // ==================================================================
   // field views
   assign chan_on          = st_r.ctrl[CTRL_ON_LSB +: 2];
   assign start_level      = st_r.ctrl[CTRL_LEVEL_LSB +: 2];
   // (RL1) alignment bits go straight to the counters
   assign center_align_sel = st_r.ctrl[CTRL_ALIGN_LSB +: 2];

   // ==================================================================
   // clock generation, all as enables on the interface clock
   // (RL20) prescaler counts interface clock cycles
   // (RL13) clock A rate from low select field
   assign clock_a_tick = (chan_on != 2'b00) && pre_tick(st_r.pre_cnt, st_r.pre[PRE_A_LSB +: 3]);
   // (RL12) clock B rate from high select field
   assign clock_b_tick = (chan_on != 2'b00) && pre_tick(st_r.pre_cnt, st_r.pre[PRE_B_LSB +: 3]);

   pwmcs_scaler u_scale_a (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (scale_load),
      .scale    (scale_val),
      .tick_in  (clock_a_tick),
      .tick_out (scaled_a_tick)
   );

   // (RL3) channel 0 source; (RL9) select used live, no sync to period
   assign sel_tick[0] = st_r.ctrl[CTRL_CLK0_POS] ? scaled_a_tick : clock_a_tick;
   // (RL2) channel 1 source
   assign sel_tick[1] = st_r.ctrl[CTRL_CLK1_POS] ? scaled_clock_b : clock_b_tick;
   assign chan_tick   = sel_tick & st_r.run;
   assign chan_run    = st_r.run;

   // ==================================================================
   // bus handshakes
   assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
   assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign wave_out_0    = st_r.wave[0];
   assign wave_out_1    = st_r.wave[1];

   // scale reload fires in the cycle the write is committed
   assign scale_load = st_r.aw_got && st_r.w_got && !st_r.bvalid
                       && st_r.w_strb[0] && reg_sel(st_r.aw_addr) == 2'd2;
   // (RL16) the register updates on the same edge, so load the incoming byte
   assign scale_val  = scale_load ? st_r.w_data[7:0] : st_r.scl_a;

   // ==================================================================
   // next state
   always_comb begin
      logic [1:0] wsel;
      logic [1:0] rsel;
      st_nxt = st_r;
      wsel   = reg_sel(st_r.aw_addr);
      rsel   = reg_sel(s_axi_araddr);

      // write channels taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = (wsel == 2'd3) ? RESP_SLVERR : RESP_OKAY;
         // only the low byte lane holds register bits
         if (st_r.w_strb[0]) begin
            unique case (wsel)
               // (RL8) (RL9) control bits take effect immediately
               2'd0: st_nxt.ctrl = st_r.w_data[7:0];
               // (RL10) (RL19) new rate at once, reserved bits dropped
               2'd1: st_nxt.pre = st_r.w_data[7:0] & PRE_WRITE_MASK;
               2'd2: st_nxt.scl_a = st_r.w_data[7:0];
               2'd3: st_nxt.bresp = RESP_SLVERR;
            endcase
         end
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // read
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         unique case (rsel)
            2'd0: st_nxt.rdata[7:0] = st_r.ctrl;
            // (RL19) reserved bits never stored, read zero
            2'd1: st_nxt.rdata[7:0] = st_r.pre;
            2'd2: st_nxt.rdata[7:0] = st_r.scl_a;
            2'd3: st_nxt.rresp = RESP_SLVERR;
         endcase
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // (RL7) prescaler held at zero while both channels are off
      if (chan_on == 2'b00) begin
         st_nxt.pre_cnt = '0;
      end else begin
         st_nxt.pre_cnt = st_r.pre_cnt + PRE_CNT_W'(1);
      end

      for (int i = 0; i < 2; i++) begin
         // (RL6) enable caught by the next selected clock tick
         if (!chan_on[i]) begin
            st_nxt.run[i]        = 1'b0;
            st_nxt.past_match[i] = 1'b0;
         end else if (!st_r.run[i] && sel_tick[i]) begin
            st_nxt.run[i]        = 1'b1;
            st_nxt.past_match[i] = 1'b0;
         end else if (st_r.run[i] && sel_tick[i]) begin
            // a match in the same tick as a period start wins: zero duty
            if (duty_match[i]) begin
               st_nxt.past_match[i] = 1'b1;
            end else if (period_start[i]) begin
               st_nxt.past_match[i] = 1'b0;
            end
         end
         // (RL4) (RL5) (RL21) level follows polarity live; may clip a pulse
         if (st_nxt.run[i]) begin
            st_nxt.wave[i] = st_nxt.past_match[i] ? ~start_level[i] : start_level[i];
         end else begin
            st_nxt.wave[i] = 1'b0;
         end
      end
   end

   // ==================================================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // (RL18) control clear
         st_r.ctrl       <= CHAN_CTRL_RST;
         // (RL22) prescale and scale clear
         st_r.pre        <= PRESCALE_SEL_RST;
         st_r.scl_a      <= SCALE_A_RST;
         st_r.pre_cnt    <= '0;
         st_r.run        <= 2'b00;
         st_r.past_match <= 2'b00;
         st_r.wave       <= 2'b00;
         st_r.aw_got     <= 1'b0;
         st_r.aw_addr    <= '0;
         st_r.w_got      <= 1'b0;
         st_r.w_data     <= 32'h0000_0000;
         st_r.w_strb     <= 4'h0;
         st_r.bvalid     <= 1'b0;
         st_r.bresp      <= RESP_OKAY;
         st_r.rvalid     <= 1'b0;
         st_r.rdata      <= 32'h0000_0000;
         st_r.rresp      <= RESP_OKAY;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : pwmcs_top

// ---- pwmcs_assertions.sv ----
// port-level checks for the pulse width front end
`timescale 1ns/1ps
module pwmcs_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        scaled_clock_b,
   input wire logic        clock_b_tick,
   input wire logic [1:0]  chan_tick,
   input wire logic [1:0]  chan_run,
   input wire logic        wave_out_0,
   input wire logic        wave_out_1
);
   import pwmcs_pkg::*;
   // ========
   // bus and channel relations
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_tick_needs_run: assert property (!(|(chan_tick & ~chan_run)))
      else $error("tick while channel idle");
   a_ch1_source: assert property (chan_tick[1] |-> clock_b_tick || scaled_clock_b)
      else $error("channel 1 tick without clock B source");
   a_run_on_tick: assert property ($rose(chan_run[1])
      |-> $past(clock_b_tick) || $past(scaled_clock_b))
      else $error("channel 1 started without a clock tick");
   a_idle_out_low: assert property (chan_run == 2'b00 |-> !wave_out_0 && !wave_out_1)
      else $error("waveform high while idle");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   c_run0: cover property ($rose(chan_run[0]));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_scaled_b: cover property (chan_tick[1] && scaled_clock_b);
endmodule : pwmcs_chk

bind pwmcs_top pwmcs_chk u_pwmcs_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .scaled_clock_b,
   .clock_b_tick, .chan_tick, .chan_run, .wave_out_0, .wave_out_1);

// ---- pwmcs_cnt_model.sv ----
// channel counters and scale B divider standing beside the front end
`timescale 1ns/1ps
module pwmcs_cnt_model #(
   parameter int PER  = 4,
   parameter int DUTY = 2,
   parameter int SB   = 2
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] chan_tick,
   input  wire logic       clock_b_tick,
   output logic [1:0]      period_start,
   output logic [1:0]      duty_match,
   output logic            scaled_clock_b
);
   int cnt [2];
   int sbc;
   // ========
   // channel counters only move on their channel tick, the scale B divider on clock_b_tick
   assign period_start = {cnt[1] == 0, cnt[0] == 0};
   assign duty_match = {cnt[1] == DUTY, cnt[0] == DUTY};
   assign scaled_clock_b = clock_b_tick && sbc == 2 * SB - 1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '{0, 0};
         sbc <= 0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (chan_tick[i]) cnt[i] <= (cnt[i] == PER - 1) ? 0 : cnt[i] + 1;
         end
         if (clock_b_tick) sbc <= scaled_clock_b ? 0 : sbc + 1;
      end
   end
endmodule : pwmcs_cnt_model

// ---- tb_top.sv ----
// self-checking bench for the pulse width front end
`timescale 1ns/1ps
module tb_top;
   import pwmcs_pkg::*;
   localparam int        SBV = 2;
   localparam logic [13:0] CTL = 14'h980, PRE = 14'h984, SCA = 14'h988;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = '0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, period_start, duty_match, chan_tick, chan_run;
   logic [1:0]  center_align_sel, r;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, scaled_clock_b, clock_b_tick, wave_out_0, wave_out_1;
   logic [31:0] d;
   int          n_errors = 0;
   int          n_tests = 0;
   int          mirror [3];
   int          k;
   always #5 aclk = ~aclk;
   pwmcs_top u_pwmcs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .period_start, .duty_match,
      .scaled_clock_b, .clock_b_tick, .chan_tick, .chan_run, .center_align_sel,
      .wave_out_0, .wave_out_1);
   pwmcs_cnt_model #(.SB(SBV)) u_pwmcs_cnt_model (.aclk, .aresetn, .chan_tick,
      .clock_b_tick, .period_start, .duty_match, .scaled_clock_b);
   // ========
   // helpers
   task chk(input logic [33:0] s, input logic [33:0] e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, s, e);
      end
   endtask : chk
   task stop_test;
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   function automatic logic [13:0] ad(input logic [11:0] b, input int i);
      return {b + 12'h060 + 12'(i), 2'b00};
   endfunction : ad
   // ready is read at the falling edge, so it equals what the next rising edge samples
   task automatic wr(input logic [13:0] a, input logic [7:0] v, output logic [1:0] rs);
      logic da, dw;
      @(posedge aclk);
      {da, dw} = 2'b00;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(da && dw)) begin
         @(negedge aclk);
         da = da || s_axi_awready;
         dw = dw || s_axi_wready;
         @(posedge aclk);
         if (da) s_axi_awvalid <= 1'b0;
         if (dw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [13:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ta;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(negedge aclk);
         ta = s_axi_arready;
         @(posedge aclk);
      end while (!ta);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      {v, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd
   // first interval after a change may be irregular, so one is skipped
   task automatic ti(input int c, input int n);
      repeat (2) do @(negedge aclk); while (!chan_tick[c]);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (!chan_tick[c]);
      chk(34'(k), 34'(n));
   endtask : ti
   task automatic wv(input int c, input logic lv);
      do @(negedge aclk); while (!(chan_tick[c] && period_start[c]));
      @(negedge aclk);
      chk(34'(c ? wave_out_1 : wave_out_0), 34'(lv));
      do @(negedge aclk); while (!(chan_tick[c] && duty_match[c]));
      @(negedge aclk);
      chk(34'(c ? wave_out_1 : wave_out_0), 34'(!lv));
   endtask : wv
   initial begin
      repeat (60000) @(posedge aclk);
      n_errors++;
      stop_test();
   end
   // ========
   // main sequence
   initial begin
      void'($urandom(4516));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ad(i < 3 ? BLOCKING_BASE : NONBLOCKING_BASE, i % 3), d, r);
         chk({r, d}, {RESP_OKAY, 32'h0});
      end
      for (int n = 0; n < 9; n++) begin
         logic [7:0] v;
         // alignment kept at zero while channels may run
         v = 8'($urandom) & (n % 3 == 0 ? 8'h3F : 8'hFF);
         wr(ad(n[0] ? BLOCKING_BASE : NONBLOCKING_BASE, n % 3), v, r);
         // reserved prescale bits are written too and must read back zero
         mirror[n % 3] = int'(n % 3 == 1 ? v & PRE_WRITE_MASK : v);
         rd(ad(n[0] ? NONBLOCKING_BASE : BLOCKING_BASE, n % 3), d, r);
         chk({r, d}, {RESP_OKAY, 32'(mirror[n % 3])});
      end
      wr(ad(BLOCKING_BASE, 3), 8'h5A, r);
      chk(34'(r), 34'(RESP_SLVERR));
      rd(ad(BLOCKING_BASE, 3), d, r);
      chk({r, d}, {RESP_SLVERR, 32'h0});
      wr(CTL, 8'h00, r);
      wr(PRE, 8'h11, r);
      k = 0;
      repeat (16) begin
         @(negedge aclk);
         k += int'(clock_b_tick);
      end
      chk(34'(k), 34'(0));
      for (int v = 0; v < 4; v++) begin
         wr(CTL, 8'(v << 6), r);
         chk(34'(center_align_sel), 34'(v));
      end
      for (int s = 0; s < 8; s++) begin
         wr(PRE, 8'(s * 17), r);
         wr(CTL, 8'h03, r);
         ti(0, 1 << s);
         ti(1, 1 << s);
      end
      wr(PRE, 8'h00, r);
      wr(CTL, 8'h11, r);
      for (int j = 0; j < 2; j++) begin
         wr(SCA, j ? 8'h00 : 8'h03, r);
         ti(0, j ? 512 : 6);
      end
      // load lands one edge before wr returns, so the count from return is one short of the full period
      wr(SCA, 8'h03, r);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (!chan_tick[0]);
      chk(34'(k), 34'(2 * 3 - 1));
      wr(CTL, 8'h22, r);
      ti(1, 2 * SBV);
      for (int c = 0; c < 4; c++) begin
         wr(CTL, 8'((1 << (c / 2)) | ((c % 2) << (2 + c / 2))), r);
         wv(c / 2, 1'(c % 2));
      end
      // reset again with a channel running and registers written
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chk(34'({chan_run, wave_out_1, wave_out_0}), 34'(0));
      for (int i = 0; i < 3; i++) begin
         rd(ad(BLOCKING_BASE, i), d, r);
         chk({r, d}, {RESP_OKAY, 32'h0});
      end
      stop_test();
   end
endmodule : tb_top
